// ==== src/supply_supervisor_lpm_control.sv ====
// supply supervisor control: apb registers, low-power states, settling, wake-up, reset
//
// Function
// (RL1) core supervisor full performance: about 2 us comparator settling delay.
// (RL2) core supervisor normal performance: about 150 us settling delay.
// (RL3) software clears full-performance bit before raising core voltage.
// (RL4) delay-pending flag set after control write; no deep sleep until clear.
// (RL5) fast wake-up if core supervisor off or full; slow if enabled normal.
// (RL6) slow wake-up lasts about 150 us.
// (RL7) core supervisor deep-sleep state from enable, keep bit and auto control.
// (RL8) core monitor: manual keeps state, auto drops one performance level.
// (RL9) supply supervisor deep-sleep state from enable, keep bit and auto control.
// (RL10) supply auto control turns supply monitor off in deep sleep.
// (RL11) overvoltage with protection enabled causes power-on reset; here only with the supply monitor enabled and outside deep sleep.
// (RL12) stuck wake-up recovered by external reset, power cycle or power-up clear.
// (RL13) software adds 150 us delay when fast wake-up is used.
// (RL14) pending flag set on write acceptance, cleared at counter expiry.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module supply_supervisor_lpm_control
  import supervisor_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_up_clear,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power mode and comparators
  input wire logic deep_sleep_req,
  input wire logic wake_req,
  input wire logic overvoltage_detect,
  input wire logic core_trip,
  // results
  output sup_state_s sup_state,
  output logic cpu_hold,
  output logic por_request,
  output logic irq
);
  logic [CTL_W-1:0] core_side_control, next_core_ctl;
  logic [CTL_W-1:0] supply_side_control, next_supply_ctl;
  logic [FLAG_W-1:0] power_flags, next_flags;
  logic [FLAG_W-1:0] flag_mask, next_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  pm_state_e pm, next_pm;
  sup_state_s next_sup;
  logic next_hold, next_por, next_irq;
  logic core_start, supply_start, core_pending, supply_pending;
  logic core_done, supply_done, wake_pending, wake_done, wake_start;
  logic [CNT_W-1:0] core_load, wake_load;
  logic acc, wr, rd, slow_wake, sleeping;
  logic [FLAG_W-1:0] ev;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign core_start = wr && paddr == ADDR_CORE_CTL; // RL14
  assign supply_start = wr && paddr == ADDR_SUPPLY_CTL; // RL14
  // settle length chosen from the value being written
  assign core_load = pwdata[B_SUP_FP] ? CNT_W'(FULL_SETTLE_CYC) // RL1
                                      : CNT_W'(SLOW_SETTLE_CYC); // RL2
  assign slow_wake = core_side_control[B_SUP_EN] && !core_side_control[B_SUP_FP]; // RL5
  assign wake_load = slow_wake ? CNT_W'(SLOW_SETTLE_CYC) : CNT_W'(FULL_SETTLE_CYC); // RL6
  assign wake_start = pm == PM_SLEEP && wake_req;
  assign sleeping = pm == PM_SLEEP;

  settle_timer u_core_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(core_start),
    .load(core_load),
    .pending(core_pending),
    .done(core_done)
  );

  settle_timer u_supply_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(supply_start),
    .load(CNT_W'(SLOW_SETTLE_CYC)),
    .pending(supply_pending),
    .done(supply_done)
  );

  settle_timer u_wake_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(wake_start),
    .load(wake_load),
    .pending(wake_pending),
    .done(wake_done)
  );

  // apb registers and flags
  always_comb begin
    next_core_ctl = core_side_control;
    next_supply_ctl = supply_side_control;
    next_mask = flag_mask;
    next_prdata = '0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    ev = '0;
    ev[F_OVP] = overvoltage_detect && supply_side_control[B_OVP_EN];
    ev[F_CORE_TRIP] = core_trip && !core_pending;
    next_flags = power_flags;
    // delay flags mirror the counters; they cannot be cleared by software
    next_flags[F_CORE_DLY] = core_pending || core_start; // RL4
    next_flags[F_SUPPLY_DLY] = supply_pending || supply_start; // RL4
    if (psel && !penable) begin
      next_pready = 1'b1;
    end
    if (acc && pready) begin
      if (wr) begin
        unique case (paddr)
          ADDR_CORE_CTL: next_core_ctl = pwdata[CTL_W-1:0];
          ADDR_SUPPLY_CTL: next_supply_ctl = pwdata[CTL_W-1:0];
          ADDR_MASK: next_mask = pwdata[FLAG_W-1:0];
          ADDR_FLAGS, ADDR_STATE, ADDR_POWER: ;
          default: next_pslverr = 1'b0;
        endcase
      end
    end
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_CORE_CTL: next_prdata = {25'h0, core_side_control};
        ADDR_SUPPLY_CTL: next_prdata = {25'h0, supply_side_control};
        ADDR_FLAGS: next_prdata = {28'h0, power_flags};
        ADDR_MASK: next_prdata = {28'h0, flag_mask};
        ADDR_STATE: next_prdata = {24'h0, sup_state};
        ADDR_POWER: next_prdata = {29'h0, cpu_hold, pm};
        default: next_pslverr = !pwrite;
      endcase
      if (!(paddr inside {ADDR_CORE_CTL, ADDR_SUPPLY_CTL, ADDR_FLAGS, ADDR_MASK,
                          ADDR_STATE, ADDR_POWER})) begin
        next_pslverr = 1'b1;
      end
    end
    // read clears sticky event flags; a new event in the same cycle wins
    // only what the read returned is cleared, so an event after the setup cycle survives
    if (rd && paddr == ADDR_FLAGS) begin
      next_flags[F_OVP] = power_flags[F_OVP] && !prdata[F_OVP];
      next_flags[F_CORE_TRIP] = power_flags[F_CORE_TRIP] && !prdata[F_CORE_TRIP];
    end
    next_flags[F_OVP] = next_flags[F_OVP] | ev[F_OVP];
    next_flags[F_CORE_TRIP] = next_flags[F_CORE_TRIP] | ev[F_CORE_TRIP];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_side_control <= CORE_CTL_RST;
      supply_side_control <= SUPPLY_CTL_RST;
      power_flags <= '0;
      flag_mask <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (power_up_clear) begin
      core_side_control <= CORE_CTL_RST;
      supply_side_control <= SUPPLY_CTL_RST;
      power_flags <= '0;
      flag_mask <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      core_side_control <= next_core_ctl;
      supply_side_control <= next_supply_ctl;
      power_flags <= next_flags;
      flag_mask <= next_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // performance state of one unit in deep sleep
  function automatic logic [1:0] deep_state(input logic [1:0] act, input logic keep,
                                            input logic auto_ctl);
    logic [1:0] r;
    r = PERF_OFF;
    // the keep bit gates both modes: without it the unit is off in deep sleep
    if (keep && auto_ctl) begin
      r = (act == PERF_FULL) ? PERF_NORMAL : PERF_OFF;
    end else if (keep) begin
      r = act;
    end
    return r;
  endfunction

  // power mode sequencing and outputs
  always_comb begin
    logic [1:0] c_sup, c_mon, s_sup, s_mon;
    c_sup = !core_side_control[B_SUP_EN] ? PERF_OFF :
            core_side_control[B_SUP_FP] ? PERF_FULL : PERF_NORMAL;
    c_mon = !core_side_control[B_MON_EN] ? PERF_OFF :
            core_side_control[B_MON_FP] ? PERF_FULL : PERF_NORMAL;
    s_sup = !supply_side_control[B_SUP_EN] ? PERF_OFF :
            supply_side_control[B_SUP_FP] ? PERF_FULL : PERF_NORMAL;
    s_mon = !supply_side_control[B_MON_EN] ? PERF_OFF :
            supply_side_control[B_MON_FP] ? PERF_FULL : PERF_NORMAL;
    next_pm = pm;
    unique case (pm)
      // entry refused while either settling delay is still running
      PM_ACTIVE: if (deep_sleep_req && !core_pending && !supply_pending) next_pm = PM_SLEEP; // RL4
      PM_SLEEP: if (wake_req) next_pm = PM_WAKE;
      PM_WAKE: if (wake_done) next_pm = PM_ACTIVE; // RL5
      default: next_pm = PM_ACTIVE;
    endcase
    next_sup.core_supervisor = c_sup;
    next_sup.core_monitor = c_mon;
    next_sup.supply_supervisor = s_sup;
    next_sup.supply_monitor = s_mon;
    if (next_pm == PM_SLEEP) begin
      next_sup.core_supervisor = deep_state(c_sup, core_side_control[B_SUP_KEEP],
                                            core_side_control[B_AUTO]); // RL7
      next_sup.core_monitor = deep_state(c_mon, 1'b1, core_side_control[B_AUTO]); // RL8
      next_sup.supply_supervisor = deep_state(s_sup, supply_side_control[B_SUP_KEEP],
                                              supply_side_control[B_AUTO]); // RL9
      // automatic control keeps the supply monitor off, which also avoids false trips
      next_sup.supply_monitor = supply_side_control[B_AUTO] ? PERF_OFF : s_mon; // RL10
    end
    next_hold = next_pm != PM_ACTIVE;
    next_por = overvoltage_detect && supply_side_control[B_OVP_EN] && s_mon != PERF_OFF
               && !sleeping; // RL11
    next_irq = |(next_flags & next_mask);
  end

  // power_up_clear also drags a stuck sleep back to active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm <= PM_ACTIVE; // RL12
      sup_state <= '0;
      cpu_hold <= 1'b0;
      por_request <= 1'b0;
      irq <= 1'b0;
    end else if (power_up_clear) begin
      pm <= PM_ACTIVE; // RL12
      sup_state <= '0;
      cpu_hold <= 1'b0;
      por_request <= 1'b0;
      irq <= 1'b0;
    end else begin
      pm <= next_pm;
      sup_state <= next_sup;
      cpu_hold <= next_hold;
      por_request <= next_por;
      irq <= next_irq;
    end
  end

  property p_delay_set;
    @(posedge clk) disable iff (!rst_n || power_up_clear)
      core_start |=> power_flags[F_CORE_DLY];
  endproperty
  a_delay_set: assert property (p_delay_set) else $error("core delay flag not set"); // RL14

  property p_full_settle;
    @(posedge clk) disable iff (!rst_n || power_up_clear)
      core_start && pwdata[B_SUP_FP] |=> core_pending [*8] ##[200:260] !core_pending;
  endproperty
  a_full_settle: assert property (p_full_settle) else $error("full settle length wrong"); // RL1

  property p_slow_settle;
    @(posedge clk) disable iff (!rst_n || power_up_clear)
      core_start && !pwdata[B_SUP_FP] && !supply_start ##1 !core_start [*8]
        |-> core_pending;
  endproperty
  a_slow_settle: assert property (p_slow_settle) else $error("slow settle ended early"); // RL2

  property p_no_sleep_pending;
    @(posedge clk) disable iff (!rst_n || power_up_clear)
      pm == PM_ACTIVE && (core_pending || supply_pending) |=> pm != PM_SLEEP;
  endproperty
  a_no_sleep_pending: assert property (p_no_sleep_pending) else $error("sleep while pending"); // RL4

  property p_wake_hold;
    @(posedge clk) disable iff (!rst_n || power_up_clear)
      pm == PM_WAKE |-> cpu_hold;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("cpu released during wake"); // RL5

  property p_core_off;
    @(posedge clk) disable iff (!rst_n || power_up_clear)
      pm == PM_SLEEP && $stable(pm) && !core_side_control[B_SUP_EN]
        |-> sup_state.core_supervisor == PERF_OFF;
  endproperty
  a_core_off: assert property (p_core_off) else $error("disabled core supervisor on"); // RL7

  property p_supply_mon_auto;
    @(posedge clk) disable iff (!rst_n || power_up_clear)
      pm == PM_SLEEP && $past(pm) == PM_SLEEP && supply_side_control[B_AUTO]
        && $stable(supply_side_control) |-> sup_state.supply_monitor == PERF_OFF;
  endproperty
  a_supply_mon_auto: assert property (p_supply_mon_auto) else $error("supply monitor on"); // RL10

  property p_ovp;
    @(posedge clk) disable iff (!rst_n || power_up_clear)
      overvoltage_detect && supply_side_control[B_OVP_EN] && supply_side_control[B_MON_EN]
        && pm != PM_SLEEP |=> por_request;
  endproperty
  a_ovp: assert property (p_ovp) else $error("no reset on overvoltage"); // RL11
endmodule

// ==== src/supervisor_pkg.sv ====
// package: register map, field layout, timing constants and types of the supply supervisor block
package supervisor_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned FULL_SETTLE_NS = 2000;
  localparam int unsigned SLOW_SETTLE_US = 150;
  localparam int unsigned FULL_SETTLE_CYC = (FULL_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLOW_SETTLE_CYC = SLOW_SETTLE_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;

  // byte offsets of the APB registers
  localparam logic [7:0] ADDR_CORE_CTL = 8'h00;
  localparam logic [7:0] ADDR_SUPPLY_CTL = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_POWER = 8'h14;

  // control field positions (same layout on both sides)
  localparam int unsigned B_SUP_EN = 0;
  localparam int unsigned B_SUP_KEEP = 1;
  localparam int unsigned B_SUP_FP = 2;
  localparam int unsigned B_AUTO = 3;
  localparam int unsigned B_MON_EN = 4;
  localparam int unsigned B_MON_FP = 5;
  localparam int unsigned B_OVP_EN = 6;
  localparam int unsigned CTL_W = 7;
  localparam logic [CTL_W-1:0] CORE_CTL_RST = 7'h05;
  localparam logic [CTL_W-1:0] SUPPLY_CTL_RST = 7'h01;

  // status flag positions
  localparam int unsigned F_CORE_DLY = 0;
  localparam int unsigned F_SUPPLY_DLY = 1;
  localparam int unsigned F_OVP = 2;
  localparam int unsigned F_CORE_TRIP = 3;
  localparam int unsigned FLAG_W = 4;

  localparam logic [1:0] PERF_OFF = 2'h0;
  localparam logic [1:0] PERF_NORMAL = 2'h1;
  localparam logic [1:0] PERF_FULL = 2'h2;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_SLEEP = 2'b01,
    PM_WAKE = 2'b10
  } pm_state_e;

  typedef struct packed {
    logic [1:0] core_supervisor;
    logic [1:0] core_monitor;
    logic [1:0] supply_supervisor;
    logic [1:0] supply_monitor;
  } sup_state_s;
endpackage

// ==== src/settle_timer.sv ====
// settling counter: loads on a start pulse, pending until it runs out
`timescale 1ns/1ps
module settle_timer
  import supervisor_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic [CNT_W-1:0] load,
  // status
  output logic pending,
  output logic done
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_pending;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_pending = pending;
    next_done = 1'b0;
    if (start) begin
      next_cnt = load;
      next_pending = 1'b1;
    end else if (pending) begin
      if (cnt <= CNT_W'(1)) begin
        next_pending = 1'b0;
        next_done = 1'b1;
        next_cnt = '0;
      end else begin
        next_cnt = cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      pending <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pending <= next_pending;
      done <= next_done;
    end
  end
endmodule

// ==== testbench/test_supply_supervisor_lpm_control.sv ====
// testbench: registers, settling flags, deep-sleep states, wake-up time, interrupt and reset paths
`timescale 1ns/1ps
module test_supply_supervisor_lpm_control;
  import supervisor_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_up_clear = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic deep_sleep_req = 1'b0;
  logic wake_req = 1'b0;
  logic overvoltage_detect = 1'b0;
  logic core_trip = 1'b0;
  sup_state_s sup_state;
  logic cpu_hold;
  logic por_request;
  logic irq;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int ts;
  logic [31:0] rd;
  logic err;

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  supply_supervisor_lpm_control u_dut (
    .clk(clk), .rst_n(rst_n), .power_up_clear(power_up_clear),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .deep_sleep_req(deep_sleep_req), .wake_req(wake_req),
    .overvoltage_detect(overvoltage_detect), .core_trip(core_trip),
    .sup_state(sup_state), .cpu_hold(cpu_hold), .por_request(por_request), .irq(irq)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // request held until pready is sampled high, the wait is cut off after 16 cycles
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk("pready", 32'h1, {31'h0, pready});
  endtask

  task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(name, exp, rd);
  endtask

  // polling resolution is a few cycles, so the windows carry that slack
  task automatic poll_clear(input int bitn, input string name, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_FLAGS, 32'h0);
      n++;
    end while (rd[bitn] !== 1'b0 && n < 8000);
    chk_rng(name, lo, hi, cyc - ts);
  endtask

  task automatic sleep_chk(input logic [7:0] exp);
    deep_sleep_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk("cpu hold asleep", 32'h1, {31'h0, cpu_hold});
    chk("sleep state", {24'h0, exp}, {24'h0, sup_state});
  endtask

  task automatic wake(input int lo, input int hi);
    deep_sleep_req <= 1'b0;
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    ts = cyc;
    while (cpu_hold !== 1'b0 && cyc - ts < 20000) @(posedge clk);
    chk_rng("wake time", lo, hi, cyc - ts);
  endtask

  task automatic sc_regs;
    rdchk("core ctl reset", ADDR_CORE_CTL, 32'h05);
    rdchk("supply ctl reset", ADDR_SUPPLY_CTL, 32'h01);
    rdchk("flags reset", ADDR_FLAGS, 32'h0);
    chk("state reset", 32'h84, {24'h0, sup_state});
    apb(1'b1, 8'h18, 32'h7f);
    chk("unmapped err", 32'h1, {31'h0, err});
    rdchk("unmapped data", 8'h18, 32'h0);
  endtask

  task automatic sc_auto_full;
    apb(1'b1, ADDR_SUPPLY_CTL, 32'h1f);
    apb(1'b1, ADDR_CORE_CTL, 32'h3f);
    ts = cyc;
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("pending flags", 32'h3, {30'h0, rd[1:0]});
    chk("active state", 32'ha9, {24'h0, sup_state});
    deep_sleep_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk("hold while pending", 32'h0, {31'h0, cpu_hold});
    poll_clear(F_CORE_DLY, "fast settle", 246, 262);
    poll_clear(F_SUPPLY_DLY, "supply settle", 18700, 18780);
    sleep_chk(8'h54);
    wake(246, 256);
    repeat (2) @(posedge clk);
    chk("state after wake", 32'ha9, {24'h0, sup_state});
  endtask

  task automatic sc_manual_normal;
    apb(1'b1, ADDR_SUPPLY_CTL, 32'h01);
    apb(1'b1, ADDR_CORE_CTL, 32'h03);
    ts = cyc;
    poll_clear(F_CORE_DLY, "slow settle", 18746, 18762);
    chk("active state", 32'h44, {24'h0, sup_state});
    sleep_chk(8'h40);
    wake(18746, 18756);
  endtask

  task automatic sc_fast_off;
    apb(1'b1, ADDR_CORE_CTL, 32'h04);
    ts = cyc;
    poll_clear(F_CORE_DLY, "off settle", 246, 262);
    sleep_chk(8'h00);
    wake(246, 256);
    apb(1'b1, ADDR_CORE_CTL, 32'h0d);
    ts = cyc;
    poll_clear(F_CORE_DLY, "auto settle", 246, 262);
    sleep_chk(8'h00);
    wake(246, 256);
  endtask

  task automatic sc_events;
    apb(1'b1, ADDR_MASK, 32'h08);
    core_trip <= 1'b1;
    @(posedge clk);
    core_trip <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq on trip", 32'h1, {31'h0, irq});
    rdchk("flags trip", ADDR_FLAGS, 32'h08);
    repeat (3) @(posedge clk);
    chk("irq after read", 32'h0, {31'h0, irq});
    overvoltage_detect <= 1'b1;
    @(posedge clk);
    overvoltage_detect <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("no reset when disabled", 32'h0, {31'h0, por_request});
    rdchk("flags overvoltage", ADDR_FLAGS, 32'h00);
    apb(1'b1, ADDR_SUPPLY_CTL, 32'h51);
    overvoltage_detect <= 1'b1;
    repeat (4) @(posedge clk);
    chk("overvoltage reset", 32'h1, {31'h0, por_request});
    chk("irq ovp masked", 32'h0, {31'h0, irq});
    rdchk("flags overvoltage set", ADDR_FLAGS, 32'h06);
    overvoltage_detect <= 1'b0;
    power_up_clear <= 1'b1;
    @(posedge clk);
    power_up_clear <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset after clear", 32'h0, {31'h0, por_request});
    rdchk("supply ctl cleared", ADDR_SUPPLY_CTL, 32'h01);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    sc_regs();
    sc_auto_full();
    sc_manual_normal();
    sc_fast_off();
    sc_events();
    print_verdict();
  end

  // whole run needs about 60000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
